// *** logic/sdr_readback.sv ***
// Diagnosis word read-back over a 16-clock full-duplex serial frame.
// Assumes SPI mode: sclk idles low, data changes on falling, sampled on rising.
`default_nettype none

module sdr_readback
    import sdr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Serial link from the controller
    input wire logic spi_sclk_i,
    input wire logic spi_csn_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Analog status inputs
    input wire logic ground_offset_flag_i,
    input wire logic [3:0] bus_fault_code_i,
    input wire logic [1:0] subbus_fault_code_i,
    input wire logic aux_supply_ok_i,
    input wire logic xcvr_supply_ok_i,
    input wire logic mcu_undervoltage_i,
    input wire logic [1:0] bus_xcvr_state_i,
    // Reset cause capture
    input wire logic reset_event_i,
    input wire logic [SDR_CAUSE_W-1:0] reset_cause_i,
    // Interrupt enables held elsewhere
    input wire logic clk_count_fail_ie_i,
    input wire logic voltage_fail_ie_i,
    // Results
    output logic [SDR_MODE_W-1:0] mode_reg_o,
    output logic mode_write_o,
    output logic frame_error_o,
    output logic voltage_fail_irq_o,
    output logic [SDR_CAUSE_W-1:0] reset_cause_field_o,
    output logic readback_target_select_o
);
    // ********************************************************************
    // Pin synchronisation
    // ********************************************************************
    localparam int unsigned NSYNC = 11;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    assign raw_in = {spi_sclk_i, spi_csn_i, spi_mosi_i, ground_offset_flag_i,
                     bus_fault_code_i, subbus_fault_code_i, mcu_undervoltage_i};
    sdr_sync #(.WIDTH(NSYNC), .RST_VAL(11'h0_200)) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(raw_in),
        .sync_o(syn)
    );
    logic sclk_s, csn_s, mosi_s, gnd_s, uv_s;
    logic [3:0] busf_s;
    logic [1:0] subf_s;
    assign sclk_s = syn[10];
    assign csn_s = syn[9];
    assign mosi_s = syn[8];
    assign gnd_s = syn[7];
    assign busf_s = syn[6:3];
    assign subf_s = syn[2:1];
    assign uv_s = syn[0];

    // Supply and state levels are two flops behind like the others
    logic [3:0] lvl_s;
    sdr_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_sync_lvl (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({aux_supply_ok_i, xcvr_supply_ok_i, bus_xcvr_state_i}),
        .sync_o(lvl_s)
    );

    // ********************************************************************
    // Edge detection
    // ********************************************************************
    logic sclk_d_ff, csn_d_ff;
    logic aux_d_ff, xcvr_d_ff, mcu_d_ff;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_d_ff <= 1'b0;
            csn_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            csn_d_ff <= csn_s;
        end
    end
    logic sclk_rise, sclk_fall, frame_start, frame_end;
    assign sclk_rise = sclk_s & ~sclk_d_ff;
    assign sclk_fall = ~sclk_s & sclk_d_ff;
    assign frame_start = ~csn_s & csn_d_ff;
    assign frame_end = csn_s & ~csn_d_ff;

    // ********************************************************************
    // Frame control
    // ********************************************************************
    sdr_state_e state_ff;
    logic [SDR_CNT_W-1:0] cnt_ff;
    logic [SDR_FRAME_BITS-1:0] rx_ff;
    logic [SDR_FRAME_BITS-1:0] tx_ff;
    logic [SDR_FRAME_BITS-1:0] diag_word;
    logic mcu_ok_ff;

    // Snapshot taken at frame start so the shifted word stays coherent
    assign diag_word = {SDR_SEL_DIAG, 1'b0, 1'b0,
                        gnd_s,
                        busf_s,
                        subf_s,
                        lvl_s[3],
                        lvl_s[2],
                        mcu_ok_ff,
                        lvl_s[1:0]};

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= SDR_IDLE;
        end else begin
            case (state_ff)
                SDR_IDLE: if (frame_start) state_ff <= SDR_SHIFT;
                SDR_SHIFT: if (frame_end) state_ff <= SDR_DONE;
                SDR_DONE: state_ff <= SDR_IDLE;
                default: state_ff <= SDR_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_ff <= '0;
            rx_ff <= '0;
        end else if (frame_start) begin
            cnt_ff <= '0;
        end else if (state_ff == SDR_SHIFT && sclk_rise && !csn_s) begin
            rx_ff <= {rx_ff[SDR_FRAME_BITS-2:0], mosi_s};
            // Saturate so long frames still count as wrong
            if (cnt_ff != '1) cnt_ff <= cnt_ff + 5'h1;
        end
    end

    // Word loaded at chip select fall; any mode, no access restriction
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_ff <= '0;
        end else if (frame_start) begin
            tx_ff <= diag_word;
        end else if (state_ff == SDR_SHIFT && sclk_fall && cnt_ff != '0) begin
            tx_ff <= {tx_ff[SDR_FRAME_BITS-2:0], 1'b0};
        end
    end
    assign spi_miso_o = tx_ff[SDR_FRAME_BITS-1];
    assign spi_miso_oe_o = (state_ff == SDR_SHIFT) & ~csn_s;

    // ********************************************************************
    // Frame completion
    // ********************************************************************
    logic len_ok, addr_ok, accept;
    assign len_ok = (cnt_ff == SDR_FRAME_LEN);
    assign addr_ok = (rx_ff[SDR_SEL_HI:SDR_SEL_LO] == SDR_SEL_DIAG);
    // A bad-length frame is dropped, or with the failure interrupt armed taken as a read only, never a write
    assign accept = (state_ff == SDR_DONE) && addr_ok && (len_ok || clk_count_fail_ie_i);

    logic read_done;
    assign read_done = accept;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_reg_o <= SDR_MODE_RST;
            mode_write_o <= 1'b0;
            readback_target_select_o <= 1'b0;
        end else begin
            mode_write_o <= 1'b0;
            if (accept && len_ok && !rx_ff[SDR_RO_BIT]) begin
                mode_reg_o <= rx_ff[SDR_MODE_W-1:0];
                mode_write_o <= 1'b1;
            end
            if (accept && len_ok) readback_target_select_o <= rx_ff[SDR_TGT_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_error_o <= 1'b0;
        end else begin
            frame_error_o <= (state_ff == SDR_DONE) && !len_ok && clk_count_fail_ie_i;
        end
    end

    // ********************************************************************
    // Sticky undervoltage flag
    // ********************************************************************
    // Undervoltage wins over the re-arm so no dip is lost
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mcu_ok_ff <= 1'b1;
        end else if (uv_s) begin
            mcu_ok_ff <= 1'b0;
        end else if (read_done) begin
            mcu_ok_ff <= 1'b1;
        end
    end

    // ********************************************************************
    // Supply failure interrupt
    // ********************************************************************
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aux_d_ff <= 1'b0;
            xcvr_d_ff <= 1'b0;
            mcu_d_ff <= 1'b1;
            voltage_fail_irq_o <= 1'b0;
        end else begin
            aux_d_ff <= lvl_s[3];
            xcvr_d_ff <= lvl_s[2];
            mcu_d_ff <= mcu_ok_ff;
            voltage_fail_irq_o <= voltage_fail_ie_i &&
                ((aux_d_ff & ~lvl_s[3]) | (xcvr_d_ff & ~lvl_s[2]) |
                 (mcu_d_ff & ~mcu_ok_ff));
        end
    end

    // ********************************************************************
    // Reset cause
    // ********************************************************************
    // Overwritten on each reset event, never cleared by reads
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reset_cause_field_o <= SDR_CAUSE_RST;
        end else if (reset_event_i) begin
            reset_cause_field_o <= reset_cause_i;
        end
    end
endmodule : sdr_readback

`default_nettype wire

// *** pkg/sdr_pkg.sv ***
// Constants, field layouts and codes for the diagnosis word read-back block.
// Assumes one 40 MHz system clock; the SPI pins are sampled by that clock.
//
// What this block does
// - Diagnosis word readable in every operating mode.
// - Select field bits 15:14 zero addresses word.
// - Bit 12 set: read only; clear: write mode.
// - Bit 11 reports ground offset outside threshold.
// - Bus fault bits 10:7 carry clamp codes.
// - Bus fault codes for wiring shorts 1001..0100.
// - Codes 0011..0001 shorts/opens, 0000 no fault.
// - Sub-bus fault bits 6:5 coded, 00 none.
// - Bit 4 aux supply healthy, zero after overload.
// - Bit 3 transceiver supply healthy, zero after overload.
// - Transceiver supply flag set again on restart.
// - Bit 2 sticky undervoltage, re-armed by read.
// - Bits 1:0 report bus transceiver state.
// - Reset cause field overwritten each reset only.
// - Wrong clock count discards writes; if enabled, flags an error and counts as a read.
// - Supply flag clearing raises interrupt when enabled.
`default_nettype none

package sdr_pkg;

    // ********************************************************************
    // Frame layout
    // ********************************************************************
    localparam int unsigned SDR_FRAME_BITS = 16;
    localparam int unsigned SDR_CNT_W = 5;
    localparam logic [SDR_CNT_W-1:0] SDR_FRAME_LEN = 5'h10;
    localparam int unsigned SDR_SEL_HI = 15;
    localparam int unsigned SDR_SEL_LO = 14;
    localparam int unsigned SDR_TGT_BIT = 13;
    localparam int unsigned SDR_RO_BIT = 12;
    localparam logic [1:0] SDR_SEL_DIAG = 2'h0;
    localparam int unsigned SDR_MODE_W = 12;

    // ********************************************************************
    // Diagnosis word fields
    // ********************************************************************
    localparam int unsigned SDR_GND_BIT = 11;
    localparam int unsigned SDR_BUSF_HI = 10;
    localparam int unsigned SDR_BUSF_LO = 7;
    localparam int unsigned SDR_SUBF_HI = 6;
    localparam int unsigned SDR_SUBF_LO = 5;
    localparam int unsigned SDR_AUX_BIT = 4;
    localparam int unsigned SDR_XCVR_BIT = 3;
    localparam int unsigned SDR_MCU_BIT = 2;
    localparam int unsigned SDR_STATE_HI = 1;
    localparam int unsigned SDR_STATE_LO = 0;
    localparam logic [3:0] SDR_BUSF_RSVD = 4'ha;
    localparam logic [3:0] SDR_BUSF_NONE = 4'h0;
    localparam int unsigned SDR_CAUSE_W = 4;
    localparam logic [SDR_CAUSE_W-1:0] SDR_CAUSE_RST = 4'h0;
    localparam logic [SDR_MODE_W-1:0] SDR_MODE_RST = 12'h000;

    typedef enum logic [1:0] {
        SDR_IDLE = 2'b00,
        SDR_SHIFT = 2'b01,
        SDR_DONE = 2'b11
    } sdr_state_e;

endpackage : sdr_pkg

`default_nettype wire

// *** logic/sdr_sync.sv ***
// Two-flop synchroniser, one per bit, for pins from outside the clock domain.
// Assumes the async reset value of each bit is given as a constant parameter.
`default_nettype none

module sdr_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule : sdr_sync

`default_nettype wire

// *** testbench/sdr_readback_asserts.sv ***
// Port-level checker for the diagnosis read-back block.
// Assumes one clock domain; bound to every sdr_readback instance.
`default_nettype none

module sdr_readback_asserts
    import sdr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Watched ports
    input wire logic spi_csn_i,
    input wire logic spi_miso_oe_o,
    input wire logic reset_event_i,
    input wire logic [SDR_CAUSE_W-1:0] reset_cause_i,
    input wire logic clk_count_fail_ie_i,
    input wire logic voltage_fail_ie_i,
    input wire logic aux_supply_ok_i,
    input wire logic xcvr_supply_ok_i,
    input wire logic mcu_undervoltage_i,
    input wire logic [SDR_MODE_W-1:0] mode_reg_o,
    input wire logic mode_write_o,
    input wire logic frame_error_o,
    input wire logic voltage_fail_irq_o,
    input wire logic [SDR_CAUSE_W-1:0] reset_cause_field_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Checks
    // ********
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence frame_open;
        $fell(spi_csn_i) ##1 !spi_csn_i;
    endsequence
    chk_oe_in_frame: assert property (frame_open |-> ##[0:3] spi_miso_oe_o)
        else $error("miso not driven in frame");
    // Six cycles leave room for the sync flops and the closing state
    chk_oe_when_idle: assert property (spi_csn_i [*6] |-> !spi_miso_oe_o)
        else $error("miso driven while idle");
    chk_mode_by_write: assert property ($changed(mode_reg_o) |-> mode_write_o || $past(mode_write_o))
        else $error("mode changed without write");
    chk_write_pulse: assert property (mode_write_o |-> spi_csn_i ##1 !mode_write_o)
        else $error("bad mode write pulse");
    chk_error_gated: assert property (frame_error_o |-> clk_count_fail_ie_i && !mode_write_o ##1 !frame_error_o)
        else $error("bad frame error pulse");
    chk_irq_gated: assert property (voltage_fail_irq_o |-> voltage_fail_ie_i
        && (!aux_supply_ok_i || !xcvr_supply_ok_i || mcu_undervoltage_i) ##1 !voltage_fail_irq_o)
        else $error("bad supply interrupt");
    chk_cause_load: assert property (reset_event_i |=> reset_cause_field_o == $past(reset_cause_i))
        else $error("reset cause not captured");
    chk_cause_hold: assert property (!reset_event_i |=> $stable(reset_cause_field_o))
        else $error("reset cause changed");
endmodule : sdr_readback_asserts

bind sdr_readback sdr_readback_asserts u_chk (.sys_clk_i, .sys_rst_i, .spi_csn_i, .spi_miso_oe_o,
    .reset_event_i, .reset_cause_i, .clk_count_fail_ie_i, .voltage_fail_ie_i, .aux_supply_ok_i,
    .xcvr_supply_ok_i, .mcu_undervoltage_i, .mode_reg_o, .mode_write_o, .frame_error_o,
    .voltage_fail_irq_o, .reset_cause_field_o);

`default_nettype wire

// *** testbench/sdr_spi_master.sv ***
// Controller-side serial master model, 200 ns link period.
// Assumes the system clock paces it; sclk idles low between frames.
`default_nettype none

module sdr_spi_master (
    // Clock
    input wire logic clk_i,
    // Serial link
    output logic sclk_o,
    output logic csn_o,
    output logic mosi_o,
    input wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        mosi_o = 1'b1;
    end
    task automatic half();
        repeat (4) @(posedge clk_i);
    endtask : half
    // A count other than 16 makes a deliberately broken frame
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = '0;
        csn_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            // Frames longer than 16 wrap round the word rather than index past it
            mosi_o <= tx[15 - (i % 16)];
            half();
            sclk_o <= 1'b1;
            rx = {rx[14:0], miso_i};
            half();
            sclk_o <= 1'b0;
        end
        half();
        csn_o <= 1'b1;
        mosi_o <= ~mosi_o;
        half();
        half();
    endtask : xfer
endmodule : sdr_spi_master

`default_nettype wire

// *** testbench/test_system_diagnosis_readback.sv ***
// Self-checking bench for the diagnosis read-back block.
// Assumes the master model and the bound checker are compiled alongside.
`default_nettype none

module test_system_diagnosis_readback
    import sdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, sys_rst_i, spi_sclk_i, spi_csn_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
    logic ground_offset_flag_i, aux_supply_ok_i, xcvr_supply_ok_i, mcu_undervoltage_i;
    logic reset_event_i, clk_count_fail_ie_i, voltage_fail_ie_i, mode_write_o, frame_error_o;
    logic voltage_fail_irq_o, readback_target_select_o;
    logic [3:0] bus_fault_code_i;
    logic [1:0] subbus_fault_code_i, bus_xcvr_state_i;
    logic [SDR_CAUSE_W-1:0] reset_cause_i, reset_cause_field_o;
    logic [SDR_MODE_W-1:0] mode_reg_o;
    logic [15:0] rx;
    logic [31:0] r, seed = 32'h0000_21F2;
    int failures = 0, checks_done = 0, n_mw = 0, n_err = 0, n_irq = 0;

    sdr_readback uut (.sys_clk_i, .sys_rst_i, .spi_sclk_i, .spi_csn_i, .spi_mosi_i, .spi_miso_o,
        .spi_miso_oe_o, .ground_offset_flag_i, .bus_fault_code_i, .subbus_fault_code_i,
        .aux_supply_ok_i, .xcvr_supply_ok_i, .mcu_undervoltage_i, .bus_xcvr_state_i,
        .reset_event_i, .reset_cause_i, .clk_count_fail_ie_i, .voltage_fail_ie_i, .mode_reg_o,
        .mode_write_o, .frame_error_o, .voltage_fail_irq_o, .reset_cause_field_o,
        .readback_target_select_o);
    sdr_spi_master m (.clk_i(sys_clk_i), .sclk_o(spi_sclk_i), .csn_o(spi_csn_i),
        .mosi_o(spi_mosi_i), .miso_i(spi_miso_o));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] exp_word(input logic uv_seen);
        return {4'h0, ground_offset_flag_i, bus_fault_code_i, subbus_fault_code_i,
            aux_supply_ok_i, xcvr_supply_ok_i, ~uv_seen, bus_xcvr_state_i};
    endfunction : exp_word
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (mode_write_o === 1'b1) n_mw++;
        if (frame_error_o === 1'b1) n_err++;
        if (voltage_fail_irq_o === 1'b1) n_irq++;
    end
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        failures++;
        results();
    end

    initial begin
        sys_rst_i = 1'b1;
        {ground_offset_flag_i, bus_fault_code_i, subbus_fault_code_i, bus_xcvr_state_i} = '0;
        {mcu_undervoltage_i, reset_event_i, reset_cause_i, clk_count_fail_ie_i} = '0;
        voltage_fail_ie_i = 1'b0;
        aux_supply_ok_i = 1'b1;
        xcvr_supply_ok_i = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            bus_fault_code_i <= i[3:0];
            subbus_fault_code_i <= i[1:0];
            ground_offset_flag_i <= r[2];
            bus_xcvr_state_i <= r[4:3];
            repeat (6) @(posedge sys_clk_i);
            m.xfer({2'b00, r[5], 1'b1, r[27:16]}, 16, rx);
            chk(rx, exp_word(1'b0));
            chk(readback_target_select_o, r[5]);
        end
        // One write, then frames that must all leave the mode value alone
        r = rnd();
        m.xfer({4'h0, r[11:0]}, 16, rx);
        m.xfer({4'h4, ~r[11:0]}, 16, rx);
        m.xfer({4'h0, ~r[11:0]}, 17, rx);
        m.xfer({4'h0, ~r[11:0]}, 15, rx);
        clk_count_fail_ie_i <= 1'b1;
        m.xfer({4'h0, ~r[11:0]}, 15, rx);
        clk_count_fail_ie_i <= 1'b0;
        chk(mode_reg_o, r[11:0]);
        chk(n_mw, 1);
        chk(n_err, 1);
        voltage_fail_ie_i <= 1'b1;
        mcu_undervoltage_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        mcu_undervoltage_i <= 1'b0;
        xcvr_supply_ok_i <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        aux_supply_ok_i <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        m.xfer(16'h1000, 16, rx);
        chk(rx, exp_word(1'b1));
        chk(n_irq, 3);
        xcvr_supply_ok_i <= 1'b1;
        aux_supply_ok_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        m.xfer(16'h1000, 16, rx);
        chk(rx, exp_word(1'b0));
        for (int i = 0; i < 2; i++) begin
            r = rnd();
            reset_cause_i <= r[3:0];
            reset_event_i <= 1'b1;
            @(posedge sys_clk_i);
            reset_event_i <= 1'b0;
            reset_cause_i <= ~r[3:0];
            repeat (3) @(posedge sys_clk_i);
            chk(reset_cause_field_o, r[3:0]);
        end
        results();
    end
endmodule : test_system_diagnosis_readback

`default_nettype wire
